//--- src/mtw_pkg.sv
// Constants and types for the mask-test and watchdog instruction unit.
package mtw_pkg;

  // Opcode groups for the two mask-test instructions.
  localparam logic [3:0] OPG_TEST_COMPLEMENT = 4'h6;
  localparam logic [3:0] OPG_TEST_MASK = 4'h7;

  // Low nibble of a mask-test opcode selects the operand modes.
  localparam logic [3:0] MODE_WORK_WORK = 4'h2;
  localparam logic [3:0] MODE_WORK_INDWORK = 4'h3;
  localparam logic [3:0] MODE_REG_REG = 4'h4;
  localparam logic [3:0] MODE_REG_INDREG = 4'h5;
  localparam logic [3:0] MODE_REG_IMM = 4'h6;
  localparam logic [3:0] MODE_INDREG_IMM = 4'h7;

  // Watchdog opcodes.
  localparam logic [7:0] OP_WATCHDOG_REFRESH = 8'h5f;
  localparam logic [7:0] OP_WATCHDOG_HALT_RUN = 8'h4f;

  // Upper nibble that turns a register operand into a working register.
  localparam logic [3:0] WORK_NIBBLE = 4'he;

  // Instruction lengths in core clock cycles.
  localparam logic [3:0] CYC_WORK_FORM = 4'h6;
  localparam logic [3:0] CYC_FULL_FORM = 4'ha;
  localparam logic [3:0] CYC_WATCHDOG_OP = 4'h6;

  // Default watchdog terminal count in core clock cycles.
  localparam int unsigned WATCHDOG_TERMINAL_DEF = 65535;

  typedef enum logic [2:0] {
    OPK_NONE = 3'h0,
    OPK_TEST_COMPLEMENT = 3'h1,
    OPK_TEST_MASK = 3'h2,
    OPK_REFRESH = 3'h3,
    OPK_HALT_RUN = 3'h4
  } op_kind_t;

  // Gray codes along idle, read, hold.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_HOLD = 2'b11
  } exec_state_t;

  // Gray codes along source pointer, source, destination pointer, dest.
  typedef enum logic [1:0] {
    RS_SRC_PTR = 2'b00,
    RS_SRC = 2'b01,
    RS_DST_PTR = 2'b11,
    RS_DST = 2'b10
  } read_step_t;

  typedef struct packed {
    op_kind_t kind;
    logic two_byte;
    logic src_indirect;
    logic src_immediate;
    logic dst_indirect;
    logic [3:0] cycles;
  } decoded_t;

endpackage

//--- src/wdt_ctl_if.sv
// Control link between the instruction unit and its watchdog timer.
`timescale 1ns/10ps
`default_nettype none
interface wdt_ctl_if;
  logic refresh;
  logic halt_run;
  logic halted;
  logic timeout;

  modport ctrl (output refresh, output halt_run, output halted,
    input timeout);
  modport timer (input refresh, input halt_run, input halted,
    output timeout);
endinterface
`default_nettype wire

//--- src/watchdog_timer.sv
// Retriggerable one-shot watchdog counter.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer
  import mtw_pkg::*;
#(
  parameter int unsigned TERMINAL = WATCHDOG_TERMINAL_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Control from the instruction unit
  wdt_ctl_if.timer ctl
);

  localparam int CW = $clog2(TERMINAL + 1);
  localparam logic [CW-1:0] LAST_COUNT = CW'(TERMINAL - 1);

  typedef struct packed {
    logic enabled;
    logic halt_run;
    logic timeout;
    logic [CW-1:0] count;
  } wd_state_t;

  wd_state_t st;
  wd_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.timeout = 1'b0;
    if (ctl.refresh) begin
      next_st.enabled = 1'b1;
      next_st.count = '0;
    end else if (ctl.halt_run && st.enabled) begin
      // The count is left alone; only the halt permission changes.
      next_st.halt_run = 1'b1;
    end
    if (st.enabled && !ctl.refresh && !(ctl.halted && !st.halt_run)) begin
      if (st.count == LAST_COUNT) begin
        // The core is reset, so the timer returns to its reset state.
        next_st.timeout = 1'b1;
        next_st.enabled = 1'b0;
        next_st.halt_run = 1'b0;
        next_st.count = '0;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctl.timeout = st.timeout;

endmodule
`default_nettype wire

//--- src/mask_test_and_watchdog_ops.sv
// Decode and execution of the mask-test and watchdog instructions.
`timescale 1ns/10ps
`default_nettype none
module mask_test_and_watchdog_ops
  import mtw_pkg::*;
#(
  parameter int unsigned WATCHDOG_TERMINAL = WATCHDOG_TERMINAL_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Instruction from the fetch unit
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_byte1,
  input wire logic [7:0] instr_byte2,
  output logic instr_done,
  // Working register pointer, upper address nibble of the working group
  input wire logic [3:0] work_group,
  // Register file read port, data returned in the same cycle
  output logic rf_rd,
  output logic [7:0] rf_addr,
  input wire logic [7:0] rf_rdata,
  // Flags
  output logic flag_we,
  output logic flag_z,
  output logic flag_s,
  output logic flag_v,
  output logic [7:0] masked_result,
  // Core state and watchdog reset
  input wire logic core_halted,
  output logic watchdog_reset
);

  typedef struct packed {
    exec_state_t state;
    read_step_t step;
    decoded_t dec;
    logic [3:0] cnt;
    logic [7:0] src_byte;
    logic [7:0] dst_byte;
    logic [7:0] ptr;
    logic [7:0] src_val;
    logic [7:0] dst_val;
    logic [7:0] result;
    logic z;
    logic s;
    logic v;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;
  decoded_t dec_in;
  logic [7:0] masked;
  logic refresh_pulse;
  logic halt_run_pulse;

  wdt_ctl_if wd_link ();

  // Maps an operand byte to a register file address.
  function automatic logic [7:0] reg_addr(input logic [7:0] operand,
                                          input logic [3:0] group);
    if (operand[7:4] == WORK_NIBBLE) begin
      reg_addr = {group, operand[3:0]};
    end else begin
      reg_addr = operand;
    end
  endfunction

  // Classifies an opcode and its operand modes.
  function automatic decoded_t decode_op(input logic [7:0] opc);
    decoded_t d;
    d = '0;
    if (opc == OP_WATCHDOG_REFRESH) begin
      d.kind = OPK_REFRESH;
      d.cycles = CYC_WATCHDOG_OP;
    end else if (opc == OP_WATCHDOG_HALT_RUN) begin
      d.kind = OPK_HALT_RUN;
      d.cycles = CYC_WATCHDOG_OP;
    end else if ((opc[7:4] == OPG_TEST_COMPLEMENT ||
                  opc[7:4] == OPG_TEST_MASK) &&
                 opc[3:0] >= MODE_WORK_WORK &&
                 opc[3:0] <= MODE_INDREG_IMM) begin
      if (opc[7:4] == OPG_TEST_COMPLEMENT) begin
        d.kind = OPK_TEST_COMPLEMENT;
      end else begin
        d.kind = OPK_TEST_MASK;
      end
      d.two_byte = (opc[3:0] == MODE_WORK_WORK) ||
                   (opc[3:0] == MODE_WORK_INDWORK);
      d.src_indirect = (opc[3:0] == MODE_WORK_INDWORK) ||
                       (opc[3:0] == MODE_REG_INDREG);
      d.src_immediate = (opc[3:0] == MODE_REG_IMM) ||
                        (opc[3:0] == MODE_INDREG_IMM);
      d.dst_indirect = (opc[3:0] == MODE_INDREG_IMM);
      d.cycles = d.two_byte ? CYC_WORK_FORM : CYC_FULL_FORM;
    end else begin
      d.kind = OPK_NONE;
    end
    decode_op = d;
  endfunction

  assign dec_in = decode_op(instr_opcode);
  assign instr_ready = (st.state == ST_IDLE);

  // Masked byte from the captured operands; operands are only read.
  always_comb begin
    if (st.dec.kind == OPK_TEST_COMPLEMENT) begin
      masked = ~st.dst_val & st.src_val;
    end else begin
      masked = st.dst_val & st.src_val;
    end
  end

  always_comb begin
    next_st = st;
    instr_done = 1'b0;
    flag_we = 1'b0;
    rf_rd = 1'b0;
    rf_addr = '0;
    refresh_pulse = 1'b0;
    halt_run_pulse = 1'b0;
    unique case (st.state)
      ST_IDLE: begin
        if (instr_valid && dec_in.kind != OPK_NONE) begin
          next_st.dec = dec_in;
          next_st.cnt = 4'h1;
          next_st.ptr = '0;
          if (dec_in.kind == OPK_REFRESH) begin
            refresh_pulse = 1'b1;
            next_st.state = ST_HOLD;
          end else if (dec_in.kind == OPK_HALT_RUN) begin
            halt_run_pulse = 1'b1;
            next_st.state = ST_HOLD;
          end else begin
            next_st.state = ST_READ;
            if (dec_in.two_byte) begin
              next_st.dst_byte = {WORK_NIBBLE, instr_byte1[7:4]};
              next_st.src_byte = {WORK_NIBBLE, instr_byte1[3:0]};
            end else if (dec_in.src_immediate) begin
              next_st.dst_byte = instr_byte1;
              next_st.src_byte = instr_byte2;
            end else begin
              next_st.src_byte = instr_byte1;
              next_st.dst_byte = instr_byte2;
            end
            if (dec_in.src_immediate) begin
              next_st.src_val = instr_byte2;
              next_st.step = dec_in.dst_indirect ? RS_DST_PTR : RS_DST;
            end else if (dec_in.src_indirect) begin
              next_st.step = RS_SRC_PTR;
            end else begin
              next_st.step = RS_SRC;
            end
          end
        end
      end
      ST_READ: begin
        next_st.cnt = st.cnt + 1'b1;
        rf_rd = 1'b1;
        unique case (st.step)
          RS_SRC_PTR: begin
            rf_addr = reg_addr(st.src_byte, work_group);
            next_st.ptr = rf_rdata;
            next_st.step = RS_SRC;
          end
          RS_SRC: begin
            rf_addr = st.dec.src_indirect ? st.ptr :
                      reg_addr(st.src_byte, work_group);
            next_st.src_val = rf_rdata;
            next_st.step = st.dec.dst_indirect ? RS_DST_PTR : RS_DST;
          end
          RS_DST_PTR: begin
            rf_addr = reg_addr(st.dst_byte, work_group);
            next_st.ptr = rf_rdata;
            next_st.step = RS_DST;
          end
          RS_DST: begin
            rf_addr = st.dec.dst_indirect ? st.ptr :
                      reg_addr(st.dst_byte, work_group);
            next_st.dst_val = rf_rdata;
            next_st.state = ST_HOLD;
          end
        endcase
      end
      ST_HOLD: begin
        if (st.cnt == st.dec.cycles - 4'h1) begin
          instr_done = 1'b1;
          next_st.state = ST_IDLE;
          // Watchdog opcodes keep the previous flag values.
          if (st.dec.kind == OPK_TEST_COMPLEMENT ||
              st.dec.kind == OPK_TEST_MASK) begin
            flag_we = 1'b1;
            next_st.result = masked;
            next_st.z = (masked == 8'h00);
            next_st.s = masked[7];
            next_st.v = 1'b0;
          end
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // No register write port exists, so operands keep their contents.
  assign flag_z = st.z;
  assign flag_s = st.s;
  assign flag_v = st.v;
  assign masked_result = st.result;

  assign wd_link.refresh = refresh_pulse;
  assign wd_link.halt_run = halt_run_pulse;
  assign wd_link.halted = core_halted;
  assign watchdog_reset = wd_link.timeout;

  watchdog_timer #(
    .TERMINAL(WATCHDOG_TERMINAL)
  ) u_watchdog (
    .core_clk(core_clk),
    .nrst(nrst),
    .ctl(wd_link.timer)
  );

endmodule
`default_nettype wire

//--- test/reg_file_model.sv
// Register file seen by the unit: combinational read port only.
`timescale 1ns/10ps
`default_nettype none
module reg_file_model (
  // Clock
  input wire logic core_clk,
  // Read port
  input wire logic rf_rd,
  input wire logic [7:0] rf_addr,
  output logic [7:0] rf_rdata
);
  logic [7:0] mem [256];
  logic [7:0] noise = 8'h5a;
  // Outside a read the lines change every cycle, so stale data never helps.
  always @(posedge core_clk) begin
    noise <= ~noise;
  end
  assign rf_rdata = rf_rd ? mem[rf_addr] : noise;
endmodule
`default_nettype wire

//--- test/mtw_asserts.sv
// Port assertions for the mask-test and watchdog instruction unit.
`timescale 1ns/10ps
`default_nettype none
module mtw_asserts
  import mtw_pkg::*;
#(
  parameter int unsigned WATCHDOG_TERMINAL = WATCHDOG_TERMINAL_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Instruction port
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_byte1,
  input wire logic instr_done,
  input wire logic [3:0] work_group,
  // Register file and flags
  input wire logic rf_rd,
  input wire logic [7:0] rf_addr,
  input wire logic flag_we,
  input wire logic flag_z,
  input wire logic flag_s,
  input wire logic flag_v,
  input wire logic [7:0] masked_result,
  // Watchdog
  input wire logic core_halted,
  input wire logic watchdog_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic take;
  logic short_op;
  logic long_op;
  logic [7:0] src;
  logic en;
  logic hr;
  int unsigned cnt;
  assign take = instr_valid && instr_ready;
  assign short_op = instr_opcode inside
    {8'h62, 8'h63, 8'h72, 8'h73, 8'h5f, 8'h4f};
  assign long_op = instr_opcode inside {[8'h64:8'h67], [8'h74:8'h77]};
  assign src = (instr_byte1[7:4] == WORK_NIBBLE) ?
    {work_group, instr_byte1[3:0]} : instr_byte1;
  // Shadow of the timer, used to pin down the moment of its reset pulse.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en <= 1'b0;
      hr <= 1'b0;
      cnt <= 0;
    end else if (take && instr_opcode == OP_WATCHDOG_REFRESH) begin
      en <= 1'b1;
      cnt <= 0;
    end else if (watchdog_reset) begin
      en <= 1'b0;
      hr <= 1'b0;
    end else begin
      if (take && instr_opcode == OP_WATCHDOG_HALT_RUN && en)
        hr <= 1'b1;
      if (en && !(core_halted && !hr))
        cnt <= cnt + 1;
    end
  end
  sequence short_done;
    ##1 (!instr_done)[*4] ##1 instr_done;
  endsequence
  sequence long_done;
    ##1 (!instr_done)[*8] ##1 instr_done;
  endsequence
  a_short_length: assert property (take && short_op |-> short_done)
    else $error("short instruction length off");
  a_long_length: assert property (take && long_op |-> long_done)
    else $error("long instruction length off");
  a_busy_after_take: assert property (
    take && (short_op || long_op) |=> !instr_ready)
    else $error("ready while busy");
  a_foreign_ignored: assert property (
    take && !short_op && !long_op |=> instr_ready && !rf_rd)
    else $error("unhandled opcode taken");
  a_work_source: assert property (
    take && instr_opcode == 8'h63 |=>
    rf_rd && rf_addr == {$past(work_group), $past(instr_byte1[3:0])})
    else $error("working source address off");
  a_reg_source: assert property (
    take && instr_opcode inside {8'h64, 8'h65, 8'h74, 8'h75} |=>
    rf_rd && rf_addr == $past(src))
    else $error("register source address off");
  a_overflow_clear: assert property (flag_we |=> !flag_v)
    else $error("overflow flag set");
  a_zero_follows: assert property (
    flag_we |=> flag_z == (masked_result == 8'h00))
    else $error("zero flag off");
  a_sign_follows: assert property (flag_we |=> flag_s == masked_result[7])
    else $error("sign flag off");
  a_flags_hold: assert property (
    !flag_we |=> $stable({flag_z, flag_s, flag_v, masked_result}))
    else $error("flags moved without update");
  a_reset_on_time: assert property (
    en && cnt == WATCHDOG_TERMINAL |-> watchdog_reset)
    else $error("watchdog reset missing");
  a_reset_not_early: assert property (
    watchdog_reset |-> en && cnt == WATCHDOG_TERMINAL)
    else $error("watchdog reset untimely");
endmodule
bind mask_test_and_watchdog_ops mtw_asserts
  #(.WATCHDOG_TERMINAL(WATCHDOG_TERMINAL)) chk (.*);
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the mask-test and watchdog instruction unit.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic instr_ready;
  logic [7:0] instr_opcode = 8'h00;
  logic [7:0] instr_byte1 = 8'h00;
  logic [7:0] instr_byte2 = 8'h00;
  logic instr_done;
  logic [3:0] work_group = 4'h1;
  logic rf_rd;
  logic [7:0] rf_addr;
  logic [7:0] rf_rdata;
  logic flag_we;
  logic flag_z;
  logic flag_s;
  logic flag_v;
  logic [7:0] masked_result;
  logic core_halted = 1'b0;
  logic watchdog_reset;
  int num_errors = 0;
  int checks_done = 0;
  int hits = 0;
  int k;
  always #4 core_clk = ~core_clk;
  mask_test_and_watchdog_ops #(.WATCHDOG_TERMINAL(20)) dut (.*);
  reg_file_model rf (.*);
  always @(negedge core_clk) begin
    if (watchdog_reset === 1'b1)
      hits++;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Called at a falling edge; returns at the falling edge of the done cycle.
  task automatic run_op(input logic [7:0] op, b1, b2);
    // A back-to-back call starts in the done cycle, while the unit is busy.
    while (instr_ready !== 1'b1) @(negedge core_clk);
    instr_valid = 1'b1;
    instr_opcode = op;
    instr_byte1 = b1;
    instr_byte2 = b2;
    @(negedge core_clk);
    instr_valid = 1'b0;
    k = 0;
    while (instr_done !== 1'b1 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    check("length", (op[3:0] < 4'h4 || op[3:0] == 4'hf) ? 4 : 8, k);
  endtask
  task automatic mt(input logic [7:0] op, b1, b2, pa, pv, da, dv, ma, mv);
    logic [7:0] r;
    r = (op[4] ? dv : ~dv) & mv;
    rf.mem[pa] = pv;
    rf.mem[da] = dv;
    rf.mem[ma] = mv;
    run_op(op, b1, b2);
    @(posedge core_clk);
    #1;
    check("result", r, masked_result);
    check("zero", r == 8'h00, flag_z);
    check("sign", r[7], flag_s);
    check("overflow", 8'h00, flag_v);
    @(negedge core_clk);
  endtask
  task automatic wait_hit(input int exp);
    k = 0;
    while (watchdog_reset !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    check("timeout at", exp, k);
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    mt(8'h62, 8'h37, 8'h00, 8'hff, 8'h00, 8'h13, 8'h45, 8'h17, 8'h01);
    mt(8'h63, 8'he5, 8'h00, 8'h15, 8'hcb, 8'h1e, 8'hf3, 8'hcb, 8'h88);
    mt(8'h64, 8'he0, 8'hd4, 8'hff, 8'h00, 8'hd4, 8'h04, 8'h10, 8'h80);
    mt(8'h65, 8'h07, 8'hdf, 8'h07, 8'h1f, 8'hdf, 8'hff, 8'h1f, 8'hbd);
    mt(8'h66, 8'hed, 8'h02, 8'hff, 8'h00, 8'h1d, 8'hf2, 8'hfe, 8'h02);
    mt(8'h67, 8'h5d, 8'h10, 8'h5d, 8'ha0, 8'ha0, 8'h0f, 8'hfe, 8'h10);
    mt(8'h72, 8'h37, 8'h00, 8'hff, 8'h00, 8'h13, 8'h45, 8'h17, 8'h02);
    mt(8'h73, 8'he5, 8'h00, 8'h15, 8'hcb, 8'h1e, 8'hf3, 8'hcb, 8'h88);
    mt(8'h74, 8'he0, 8'hd4, 8'hff, 8'h00, 8'hd4, 8'h08, 8'h10, 8'h04);
    mt(8'h75, 8'h07, 8'hdf, 8'h07, 8'h1f, 8'hdf, 8'h00, 8'h1f, 8'hbd);
    mt(8'h76, 8'hed, 8'h02, 8'hff, 8'h00, 8'h1d, 8'hf1, 8'hfe, 8'h02);
    mt(8'h77, 8'h5d, 8'h10, 8'h5d, 8'ha0, 8'ha0, 8'h0f, 8'hfe, 8'h10);
    check("timeouts", 8'h00, hits);
    instr_valid = 1'b1;
    instr_opcode = 8'h68;
    repeat (3) @(negedge core_clk);
    check("ignored", 8'h01, instr_ready);
    instr_valid = 1'b0;
    run_op(8'h4f, 8'h00, 8'h00);
    run_op(8'h5f, 8'h00, 8'h00);
    core_halted = 1'b1;
    repeat (40) @(negedge core_clk);
    check("halt stop", 8'h00, hits);
    core_halted = 1'b0;
    repeat (5) run_op(8'h5f, 8'h00, 8'h00);
    check("refreshed", 8'h00, hits);
    check("kept", 8'h00, masked_result);
    wait_hit(16);
    @(negedge core_clk);
    run_op(8'h5f, 8'h00, 8'h00);
    run_op(8'h4f, 8'h00, 8'h00);
    core_halted = 1'b1;
    wait_hit(10);
    core_halted = 1'b0;
    repeat (30) @(negedge core_clk);
    check("timeouts", 8'h02, hits);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
